// File: design/frame_format_pkg.sv
// package: buffer frame layout, status bit positions and limits
package frame_format_pkg;

  localparam int ADDR_W = 12;
  localparam int COUNT_W = 11;
  localparam int LEN_W = 12;

  // word positions inside a frame structure
  localparam logic [ADDR_W-1:0] STATUS_WORD_IDX = 12'h000;
  localparam logic [ADDR_W-1:0] COUNT_WORD_IDX = 12'h001;
  localparam logic [ADDR_W-1:0] DATA_WORD_IDX = 12'h002;
  localparam int DATA_BYTE_OFFSET = 4;
  localparam logic [COUNT_W-1:0] OVERHEAD_BYTES = 11'h006;

  // size limits
  localparam int PAGE_BYTES = 256;
  localparam int MAX_PAGES = 6;
  localparam logic [COUNT_W-1:0] MAX_BYTE_COUNT = 11'(PAGE_BYTES * MAX_PAGES);
  localparam logic [LEN_W-1:0] MAX_DATA_BYTES = 12'h5FB;
  localparam logic [LEN_W-1:0] MAX_CABLE_BYTES = 12'h5EE;
  localparam logic [LEN_W-1:0] MIN_CABLE_BYTES = 12'h040;
  localparam logic [LEN_W-1:0] ADDR_BYTES = 12'h006;

  // control byte layout
  localparam int CTRL_ODD_BIT = 5;
  localparam int CTRL_CRC_BIT = 4;
  localparam logic [7:0] RX_CTRL_BASE = 8'h40;

  // receive status word layout
  localparam int ST_ALIGN_BIT = 15;
  localparam int ST_BCAST_BIT = 14;
  localparam int ST_CRC_BIT = 13;
  localparam int ST_ODD_BIT = 12;
  localparam int ST_LONG_BIT = 11;
  localparam int ST_SHORT_BIT = 10;
  localparam int ST_HASH_LSB = 1;
  localparam int ST_GROUP_BIT = 0;

  // fcs generator
  localparam logic [31:0] CRC_POLY_REFL = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam int HASH_MSB = 31;
  localparam int HASH_LSB = 26;

  localparam logic [15:0] WORD_RESET = 16'h0000;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } byte_beat_type;

  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [15:0] data;
  } mem_write_type;

  typedef struct packed {
    logic align_err;
    logic crc_err;
  } rx_error_type;

endpackage

// File: design/dest_addr_crc.sv
// byte-serial ethernet crc over the destination address
`timescale 1ns/10ps
`default_nettype none
module dest_addr_crc (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // byte input
  input wire logic restart,
  input wire logic byte_en,
  input wire logic [7:0] byte_in,
  // running remainder
  output logic [31:0] crc
);
  import frame_format_pkg::*;

  logic [31:0] crc_ff;
  logic [31:0] nxt_crc;

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY_REFL) : (r >> 1);
    end
    return r;
  endfunction

  // same polynomial and bit order as the frame check sequence
  always_comb begin
    nxt_crc = crc_ff;
    if (restart) begin
      nxt_crc = CRC_INIT;
    end else if (byte_en) begin
      nxt_crc = crc_step(crc_ff, byte_in);
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      crc_ff <= CRC_INIT;
    end else begin
      crc_ff <= nxt_crc;
    end
  end

  assign crc = crc_ff;

endmodule // dest_addr_crc
`default_nettype wire

// File: design/packet_buffer_frame_format.sv
// frame formatter between the packet buffer and the transmit/receive engine
`timescale 1ns/10ps
`default_nettype none
module packet_buffer_frame_format (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // receive engine byte stream
  input wire frame_format_pkg::byte_beat_type rx_beat,
  input wire frame_format_pkg::rx_error_type rx_err,
  input wire logic [frame_format_pkg::ADDR_W-1:0] rx_base,
  input wire logic [63:0] group_table,
  // receive buffer writes and result
  output frame_format_pkg::mem_write_type rx_wr,
  output logic rx_done,
  output logic [15:0] rx_status,
  output logic rx_hash_hit,
  // transmit control
  input wire logic tx_start,
  input wire logic [frame_format_pkg::ADDR_W-1:0] tx_base,
  input wire logic suppress_fcs_setting,
  input wire logic tx_ready,
  input wire logic tx_status_valid,
  input wire logic [15:0] tx_status_in,
  // transmit buffer access
  output logic mem_rd_en,
  output logic [frame_format_pkg::ADDR_W-1:0] mem_rd_addr,
  input wire logic [15:0] mem_rd_data,
  output frame_format_pkg::mem_write_type tx_wr,
  // transmit byte stream
  output frame_format_pkg::byte_beat_type tx_beat,
  output logic tx_append_fcs,
  output logic tx_busy,
  output logic tx_done
);
  import frame_format_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // shared helpers

  function automatic logic [ADDR_W-1:0] word_addr(input logic [ADDR_W-1:0] base,
                                                  input logic [ADDR_W-1:0] idx);
    return ADDR_W'(base + idx);
  endfunction

  // hash bit 5 is the x^31 term, which the reflected remainder keeps in bit 0
  function automatic logic [5:0] hash_of(input logic [31:0] c);
    logic [5:0] h;
    for (int i = 0; i < 6; i++) begin
      h[5 - i] = c[i];
    end
    return h;
  endfunction

  function automatic logic [LEN_W-1:0] cap_len(input logic [LEN_W-1:0] n);
    return (n > MAX_DATA_BYTES) ? MAX_DATA_BYTES : n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // receive side

  typedef enum logic [2:0] {
    R_IDLE = 3'b000,
    R_DATA = 3'b001,
    R_CTRL = 3'b010,
    R_COUNT = 3'b011,
    R_STATUS = 3'b100
  } rx_state_type;

  rx_state_type rstate_ff, nxt_rstate;
  logic [LEN_W-1:0] rlen_ff, nxt_rlen;
  logic [7:0] rlo_ff, nxt_rlo;
  logic bcast_ff, nxt_bcast;
  logic group_ff, nxt_group;
  rx_error_type rerr_ff, nxt_rerr;
  mem_write_type rx_wr_ff, nxt_rx_wr;
  logic rx_done_ff, nxt_rx_done;
  logic [15:0] rx_status_ff, nxt_rx_status;
  logic rx_hit_ff, nxt_rx_hit;
  logic [5:0] hash_ff, nxt_hash;
  logic [31:0] da_crc;
  logic crc_restart, crc_en;
  logic [LEN_W-1:0] stored;
  logic [LEN_W-1:0] rpos;
  logic odd;

  assign stored = cap_len(rlen_ff);
  assign odd = stored[0];
  // byte position of the current beat; idle means a new frame starts at zero
  assign rpos = (rstate_ff == R_IDLE) ? '0 : rlen_ff;
  // reseed between frames so a back-to-back frame starts from a clean remainder
  assign crc_restart = (rstate_ff == R_IDLE) ? !rx_beat.valid : (rstate_ff != R_DATA);
  assign crc_en = rx_beat.valid && (rpos < ADDR_BYTES);

  dest_addr_crc u_da_crc (
    .clock(clock),
    .arst_n(arst_n),
    .restart(crc_restart),
    .byte_en(crc_en),
    .byte_in(rx_beat.data),
    .crc(da_crc)
  );

  always_comb begin
    nxt_rstate = rstate_ff;
    nxt_rlen = rlen_ff;
    nxt_rlo = rlo_ff;
    nxt_bcast = bcast_ff;
    nxt_group = group_ff;
    nxt_rerr = rerr_ff;
    nxt_rx_wr = '0;
    nxt_rx_done = 1'b0;
    nxt_rx_status = rx_status_ff;
    nxt_rx_hit = rx_hit_ff;
    nxt_hash = hash_ff;
    case (rstate_ff)
      R_IDLE, R_DATA: begin
        if (rx_beat.valid) begin
          if (rstate_ff == R_IDLE) begin
            nxt_bcast = 1'b1;
            nxt_group = rx_beat.data[0];
          end
          // every byte below the data limit stored as received, addresses and length/type alike
          if (rpos < MAX_DATA_BYTES) begin
            if (!rpos[0]) begin
              nxt_rlo = rx_beat.data;
            end else begin
              nxt_rx_wr.en = 1'b1;
              nxt_rx_wr.addr = word_addr(rx_base, DATA_WORD_IDX + ADDR_W'(rpos >> 1));
              nxt_rx_wr.data = {rx_beat.data, rlo_ff};
            end
          end
          if ((rpos < ADDR_BYTES) && (rx_beat.data != 8'hFF)) begin
            nxt_bcast = 1'b0;
          end
          if (rpos != {LEN_W{1'b1}}) begin
            nxt_rlen = LEN_W'(rpos + 12'h001);
          end
          nxt_rstate = rx_beat.last ? R_CTRL : R_DATA;
          if (rx_beat.last) begin
            nxt_rerr = rx_err;
          end
        end
        if (rstate_ff == R_DATA && rlen_ff == ADDR_BYTES) begin
          nxt_hash = hash_of(da_crc);
        end
      end
      R_CTRL: begin
        // control byte in the high byte of the last word
        nxt_rx_wr.en = 1'b1;
        nxt_rx_wr.addr = word_addr(rx_base, DATA_WORD_IDX + ADDR_W'(stored >> 1));
        nxt_rx_wr.data = {RX_CTRL_BASE | (8'(odd) << CTRL_ODD_BIT), odd ? rlo_ff : 8'h00};
        if (rlen_ff <= ADDR_BYTES) begin
          nxt_hash = hash_of(da_crc);
        end
        nxt_rstate = R_COUNT;
      end
      R_COUNT: begin
        // bytes = status + count + data pairs + control word; always even
        nxt_rx_wr.en = 1'b1;
        nxt_rx_wr.addr = word_addr(rx_base, COUNT_WORD_IDX);
        nxt_rx_wr.data = 16'(OVERHEAD_BYTES) + 16'({stored[LEN_W-1:1], 1'b0});
        nxt_rstate = R_STATUS;
      end
      R_STATUS: begin
        // status goes to the buffer word and to the rx_status output
        nxt_rx_status = WORD_RESET;
        nxt_rx_status[ST_ALIGN_BIT] = rerr_ff.align_err;
        nxt_rx_status[ST_BCAST_BIT] = bcast_ff;
        nxt_rx_status[ST_CRC_BIT] = rerr_ff.crc_err;
        nxt_rx_status[ST_ODD_BIT] = odd;
        nxt_rx_status[ST_LONG_BIT] = rlen_ff > MAX_CABLE_BYTES;
        nxt_rx_status[ST_SHORT_BIT] = rlen_ff < MIN_CABLE_BYTES;
        nxt_rx_status[ST_HASH_LSB +: 6] = hash_ff;
        nxt_rx_status[ST_GROUP_BIT] = group_ff;
        nxt_rx_wr.en = 1'b1;
        nxt_rx_wr.addr = word_addr(rx_base, STATUS_WORD_IDX);
        nxt_rx_wr.data = nxt_rx_status;
        nxt_rx_hit = group_ff && group_table[hash_ff];
        nxt_rx_done = 1'b1;
        nxt_rstate = R_IDLE;
      end
      default: nxt_rstate = R_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rstate_ff <= R_IDLE;
      rlen_ff <= '0;
      rlo_ff <= 8'h00;
      bcast_ff <= 1'b0;
      group_ff <= 1'b0;
      rerr_ff <= '0;
      rx_wr_ff <= '0;
      rx_done_ff <= 1'b0;
      rx_status_ff <= WORD_RESET;
      rx_hit_ff <= 1'b0;
      hash_ff <= 6'h00;
    end else begin
      rstate_ff <= nxt_rstate;
      rlen_ff <= nxt_rlen;
      rlo_ff <= nxt_rlo;
      bcast_ff <= nxt_bcast;
      group_ff <= nxt_group;
      rerr_ff <= nxt_rerr;
      rx_wr_ff <= nxt_rx_wr;
      rx_done_ff <= nxt_rx_done;
      rx_status_ff <= nxt_rx_status;
      rx_hit_ff <= nxt_rx_hit;
      hash_ff <= nxt_hash;
    end
  end

  assign rx_wr = rx_wr_ff;
  assign rx_done = rx_done_ff;
  assign rx_status = rx_status_ff;
  assign rx_hash_hit = rx_hit_ff;

  ////////////////////////////////////////////////////////////////////////////
  // transmit side

  typedef enum logic [2:0] {
    T_IDLE = 3'b000,
    T_READ = 3'b001,
    T_WAIT = 3'b010,
    T_GRAB = 3'b011,
    T_SEND = 3'b100,
    T_STAT = 3'b101
  } tx_state_type;

  typedef enum logic [1:0] {
    P_CNT = 2'b00,
    P_CTL = 2'b01,
    P_DAT = 2'b10
  } tx_phase_type;

  tx_state_type tstate_ff, nxt_tstate;
  tx_phase_type phase_ff, nxt_phase;
  logic [ADDR_W-1:0] tbase_ff, nxt_tbase;
  logic [ADDR_W-1:0] tidx_ff, nxt_tidx;
  logic [COUNT_W-1:0] tcount_ff, nxt_tcount;
  logic [COUNT_W-1:0] total_ff, nxt_total;
  logic [COUNT_W-1:0] sent_ff, nxt_sent;
  logic [15:0] word_ff, nxt_word;
  logic rd_en_ff, nxt_rd_en;
  byte_beat_type tx_beat_ff, nxt_tx_beat;
  logic fcs_ff, nxt_fcs;
  logic tx_done_ff, nxt_tx_done;
  mem_write_type tx_wr_ff, nxt_tx_wr;
  logic [COUNT_W-1:0] cnt_read;
  logic ctl_odd;

  // host-written count with bit zero ignored, clamped to six pages
  assign cnt_read = ({mem_rd_data[COUNT_W-1:1], 1'b0} > MAX_BYTE_COUNT) ?
                    MAX_BYTE_COUNT : {mem_rd_data[COUNT_W-1:1], 1'b0};
  assign ctl_odd = mem_rd_data[8 + CTRL_ODD_BIT];

  always_comb begin
    nxt_tstate = tstate_ff;
    nxt_phase = phase_ff;
    nxt_tbase = tbase_ff;
    nxt_tidx = tidx_ff;
    nxt_tcount = tcount_ff;
    nxt_total = total_ff;
    nxt_sent = sent_ff;
    nxt_word = word_ff;
    nxt_rd_en = 1'b0;
    nxt_tx_beat = tx_beat_ff;
    nxt_fcs = fcs_ff;
    nxt_tx_done = 1'b0;
    nxt_tx_wr = '0;
    case (tstate_ff)
      T_IDLE: begin
        if (tx_start) begin
          nxt_tbase = tx_base;
          nxt_tidx = COUNT_WORD_IDX;
          nxt_phase = P_CNT;
          nxt_sent = '0;
          nxt_tstate = T_READ;
        end
      end
      T_READ: begin
        nxt_rd_en = 1'b1;
        nxt_tstate = T_WAIT;
      end
      T_WAIT: nxt_tstate = T_GRAB;
      T_GRAB: begin
        nxt_word = mem_rd_data;
        nxt_tstate = T_READ;
        case (phase_ff)
          P_CNT: begin
            nxt_tcount = cnt_read;
            nxt_tidx = ADDR_W'((cnt_read >> 1) - 11'h001);
            nxt_phase = P_CTL;
            if (cnt_read < OVERHEAD_BYTES) begin
              nxt_tstate = T_STAT;
            end
          end
          P_CTL: begin
            // byte before the control byte goes out only when odd is set
            nxt_total = COUNT_W'(tcount_ff - OVERHEAD_BYTES) + COUNT_W'(ctl_odd);
            // host crc request counts only when fcs insertion is suppressed
            nxt_fcs = suppress_fcs_setting ? mem_rd_data[8 + CTRL_CRC_BIT] : 1'b1;
            nxt_tidx = DATA_WORD_IDX;
            nxt_phase = P_DAT;
            if (nxt_total == '0) begin
              nxt_tstate = T_STAT;
            end
          end
          default: nxt_tstate = T_SEND;
        endcase
      end
      T_SEND: begin
        if (!tx_beat_ff.valid) begin
          // bytes go out exactly as the host wrote them
          nxt_tx_beat.valid = 1'b1;
          nxt_tx_beat.data = sent_ff[0] ? word_ff[15:8] : word_ff[7:0];
          nxt_tx_beat.last = COUNT_W'(sent_ff + 11'h001) == total_ff;
        end else if (tx_ready) begin
          nxt_tx_beat = '0;
          nxt_sent = COUNT_W'(sent_ff + 11'h001);
          if (tx_beat_ff.last) begin
            nxt_tstate = T_STAT;
          end else if (sent_ff[0]) begin
            nxt_tidx = ADDR_W'(tidx_ff + 12'h001);
            nxt_tstate = T_READ;
          end
        end
      end
      T_STAT: begin
        // engine fills in the status word after completion
        if (tx_status_valid) begin
          nxt_tx_wr.en = 1'b1;
          nxt_tx_wr.addr = word_addr(tbase_ff, STATUS_WORD_IDX);
          nxt_tx_wr.data = tx_status_in;
          nxt_tx_done = 1'b1;
          nxt_tstate = T_IDLE;
        end
      end
      default: nxt_tstate = T_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tstate_ff <= T_IDLE;
      phase_ff <= P_CNT;
      tbase_ff <= '0;
      tidx_ff <= '0;
      tcount_ff <= '0;
      total_ff <= '0;
      sent_ff <= '0;
      word_ff <= WORD_RESET;
      rd_en_ff <= 1'b0;
      tx_beat_ff <= '0;
      fcs_ff <= 1'b1;
      tx_done_ff <= 1'b0;
      tx_wr_ff <= '0;
    end else begin
      tstate_ff <= nxt_tstate;
      phase_ff <= nxt_phase;
      tbase_ff <= nxt_tbase;
      tidx_ff <= nxt_tidx;
      tcount_ff <= nxt_tcount;
      total_ff <= nxt_total;
      sent_ff <= nxt_sent;
      word_ff <= nxt_word;
      rd_en_ff <= nxt_rd_en;
      tx_beat_ff <= nxt_tx_beat;
      fcs_ff <= nxt_fcs;
      tx_done_ff <= nxt_tx_done;
      tx_wr_ff <= nxt_tx_wr;
    end
  end

  assign mem_rd_en = rd_en_ff;
  assign mem_rd_addr = word_addr(tbase_ff, tidx_ff);
  assign tx_beat = tx_beat_ff;
  assign tx_append_fcs = fcs_ff;
  assign tx_busy = (tstate_ff != T_IDLE);
  assign tx_done = tx_done_ff;
  assign tx_wr = tx_wr_ff;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_rx_count_even: assert property (rx_wr_ff.en && rstate_ff == R_STATUS |->
    !rx_wr_ff.data[0] && rx_wr_ff.data <= 16'(MAX_BYTE_COUNT))
    else $error("receive byte count odd or too large");
  a_rx_ctrl_form: assert property (rx_wr_ff.en && rstate_ff == R_COUNT |->
    rx_wr_ff.data[15:14] == 2'b01 && rx_wr_ff.data[12:8] == 5'h00)
    else $error("receive control byte malformed");
  a_rx_odd_match: assert property (rx_done_ff |->
    rx_status_ff[ST_ODD_BIT] == (rlen_ff[0] || rlen_ff > MAX_DATA_BYTES))
    else $error("odd flag disagrees with length");
  a_rx_size_flags: assert property (rx_done_ff |->
    rx_status_ff[ST_SHORT_BIT] == (rlen_ff < MIN_CABLE_BYTES) &&
    rx_status_ff[ST_LONG_BIT] == (rlen_ff > MAX_CABLE_BYTES))
    else $error("size flags wrong");
  a_rx_status_seq: assert property (rx_beat.valid && rx_beat.last && rstate_ff != R_CTRL
    && rstate_ff != R_COUNT && rstate_ff != R_STATUS |-> ##4 rx_wr_ff.en ##0
    rx_wr_ff.addr == rx_base && rx_done_ff)
    else $error("status word not written at frame start");
  a_rx_filter_hit: assert property (rx_done_ff |->
    rx_hash_hit == (rx_status_ff[ST_GROUP_BIT] &&
    group_table[rx_status_ff[ST_HASH_LSB +: 6]]))
    else $error("group filter result wrong");
  a_rx_data_cap: assert property (rx_wr_ff.en && rstate_ff == R_DATA |->
    rx_wr_ff.addr < word_addr(rx_base, DATA_WORD_IDX + ADDR_W'(MAX_DATA_BYTES >> 1) +
    12'h001))
    else $error("data written past frame limit");
  a_tx_fcs_select: assert property (tstate_ff == T_GRAB && phase_ff == P_CTL |=>
    fcs_ff == (!suppress_fcs_setting || $past(mem_rd_data[8 + CTRL_CRC_BIT])))
    else $error("fcs append decision wrong");
  a_tx_byte_total: assert property (tx_beat_ff.valid && tx_beat_ff.last |->
    COUNT_W'(sent_ff + 11'h001) == total_ff && total_ff <= MAX_BYTE_COUNT)
    else $error("transmit byte total wrong");
  a_tx_beat_hold: assert property (tx_beat_ff.valid && !tx_ready |=>
    tx_beat_ff.valid && $stable(tx_beat_ff.data))
    else $error("transmit byte dropped under backpressure");
  a_tx_status_wr: assert property (tstate_ff == T_STAT && tx_status_valid |=>
    tx_wr_ff.en && tx_wr_ff.addr == tbase_ff && tx_wr_ff.data == $past(tx_status_in))
    else $error("transmit status not stored");

  c_rx_odd_frame: cover property (rx_done_ff && rx_status_ff[ST_ODD_BIT]);
  c_rx_group_hit: cover property (rx_done_ff && rx_hash_hit);
  c_tx_odd_last: cover property (tx_beat_ff.valid && tx_beat_ff.last && sent_ff[0] == 1'b0);
  c_tx_done: cover property (tx_done_ff);

endmodule // packet_buffer_frame_format
`default_nettype wire

// File: test/buffer_mem_model.sv
// buffer memory model: host side of the packet buffer
`timescale 1ns/10ps
`default_nettype none
module buffer_mem_model (
  // clock
  input wire logic clock,
  // formatter writes
  input wire frame_format_pkg::mem_write_type rx_wr,
  input wire frame_format_pkg::mem_write_type tx_wr,
  // formatter reads, one cycle latency
  input wire logic rd_en,
  input wire logic [frame_format_pkg::ADDR_W-1:0] rd_addr,
  output logic [15:0] rd_data
);
  import frame_format_pkg::*;
  logic [15:0] mem [0:4095];
  initial rd_data = 16'h0000;
  always @(posedge clock) begin
    if (rx_wr.en) begin
      mem[rx_wr.addr] <= rx_wr.data;
    end
    if (tx_wr.en) begin
      mem[tx_wr.addr] <= tx_wr.data;
    end
    // read data holds until the next read
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // buffer_mem_model
`default_nettype wire

// File: test/tb.sv
// self-checking bench for the packet buffer frame formatter
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb;
  import frame_format_pkg::*;
  logic clock, arst_n, tx_start, suppress_fcs_setting, tx_ready, tx_status_valid;
  logic rx_done, rx_hash_hit, mem_rd_en, tx_append_fcs, tx_busy, tx_done, fcs_seen;
  logic [1:0] stall_cnt;
  logic [ADDR_W-1:0] rx_base, tx_base, mem_rd_addr;
  logic [15:0] rx_status, tx_status_in, mem_rd_data;
  logic [63:0] group_table;
  byte_beat_type rx_beat, tx_beat;
  rx_error_type rx_err;
  mem_write_type rx_wr, tx_wr;
  logic [7:0] got [$];
  logic [7:0] da [4] = '{8'hED, 8'h0D, 8'h01, 8'h2F};
  logic [5:0] hv [4] = '{6'h00, 6'h10, 6'h27, 6'h3F};
  int num_errors = 0;
  int checks_done = 0;

  packet_buffer_frame_format i_dut (
    .clock(clock), .arst_n(arst_n), .rx_beat(rx_beat), .rx_err(rx_err),
    .rx_base(rx_base), .group_table(group_table), .rx_wr(rx_wr), .rx_done(rx_done),
    .rx_status(rx_status), .rx_hash_hit(rx_hash_hit), .tx_start(tx_start),
    .tx_base(tx_base), .suppress_fcs_setting(suppress_fcs_setting), .tx_ready(tx_ready),
    .tx_status_valid(tx_status_valid), .tx_status_in(tx_status_in),
    .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
    .tx_wr(tx_wr), .tx_beat(tx_beat), .tx_append_fcs(tx_append_fcs),
    .tx_busy(tx_busy), .tx_done(tx_done)
  );
  buffer_mem_model i_mem (
    .clock(clock), .rx_wr(rx_wr), .tx_wr(tx_wr), .rd_en(mem_rd_en),
    .rd_addr(mem_rd_addr), .rd_data(mem_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // transmit engine side: stalls one cycle in four, collects bytes
  always @(posedge clock) begin
    stall_cnt <= stall_cnt + 2'h1;
    tx_ready <= stall_cnt != 2'h3;
    if (tx_beat.valid && tx_ready) begin
      got.push_back(tx_beat.data);
      fcs_seen <= tx_append_fcs;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // sel 0: rx_done, 1: tx_done, 2: nb bytes collected
  task automatic wait_on(input int sel, input int nb);
    int i;
    for (i = 0; i < 2000; i++) begin
      @(posedge clock);
      #1;
      if (sel == 0 ? rx_done === 1'b1 : sel == 1 ? tx_done === 1'b1 : got.size() >= nb) break;
    end
    if (i == 2000) begin
      num_errors++;
      $display("unexpected at %0t: wait ran out", $time);
      report_and_stop();
    end
  endtask

  function automatic logic [7:0] rxb(input int k, input logic [7:0] d0, input logic bc);
    if (k < 6) return bc ? 8'hFF : (k == 0 ? d0 : 8'h00);
    return k[7:0];
  endfunction

  task automatic rx_frame(input logic [11:0] b, input int n, input logic [7:0] d0,
    input logic bc, input logic [1:0] er, input logic [5:0] h, input logic [15:0] m,
    input logic hit);
    logic [15:0] st;
    logic od;
    // bytes past the data limit are dropped, leaving an odd stored tail
    od = n[0] || n > MAX_DATA_BYTES;
    st = {er[1], bc, er[0], od, n > 1518, n < 64, 3'b000, h, bc | d0[0]};
    for (int k = 0; k < n; k++) begin
      @(posedge clock);
      rx_base <= b;
      rx_beat <= '{1'b1, rxb(k, d0, bc), k == n - 1};
      rx_err <= er;
    end
    @(posedge clock);
    rx_beat <= '0;
    wait_on(0, 0);
    `CHK(rx_status & m, st & m)
    `CHK(rx_hash_hit, hit)
    // the status word lands in the buffer one edge after rx_done
    @(posedge clock);
    #1;
    `CHK(i_mem.mem[b] & m, st & m)
    if (n <= 1531) begin
      `CHK(i_mem.mem[b + 1], 16'(6 + 2 * (n / 2)))
      `CHK(i_mem.mem[b + 2 + n / 2], {2'b01, od, 5'b0, od ? rxb(n - 1, d0, bc) : 8'h00})
      for (int j = 0; j < n / 2; j++) begin
        `CHK(i_mem.mem[b + 2 + j], {rxb(2 * j + 1, d0, bc), rxb(2 * j, d0, bc)})
      end
    end
  endtask

  task automatic tx_frame(input logic [11:0] b, input int nb, input logic sup,
    input logic crc, input logic fcs);
    logic od;
    od = nb[0];
    got.delete();
    i_mem.mem[b + 1] = 16'(7 + 2 * (nb / 2));
    for (int j = 0; j < nb / 2; j++) begin
      i_mem.mem[b + 2 + j] = {8'(2 * j + 161), 8'(2 * j + 160)};
    end
    i_mem.mem[b + 2 + nb / 2] = {2'b11, od, crc, 4'h0, od ? 8'(nb + 159) : 8'h5A};
    @(posedge clock);
    tx_start <= 1'b1;
    tx_base <= b;
    suppress_fcs_setting <= sup;
    @(posedge clock);
    tx_start <= 1'b0;
    wait_on(2, nb);
    `CHK(tx_busy, 1'b1)
    tx_status_valid <= 1'b1;
    tx_status_in <= 16'(16'hC000 + nb);
    wait_on(1, 0);
    tx_status_valid <= 1'b0;
    // the status word lands in the buffer one edge after tx_done
    @(posedge clock);
    #1;
    `CHK(got.size(), nb)
    for (int k = 0; k < nb; k++) begin
      `CHK(got[k], 8'(160 + k))
    end
    `CHK(fcs_seen, fcs)
    `CHK(i_mem.mem[b], 16'(16'hC000 + nb))
    `CHK(tx_busy, 1'b0)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    rx_beat = '0;
    rx_err = '0;
    rx_base = '0;
    group_table = '0;
    tx_start = 1'b0;
    tx_base = '0;
    suppress_fcs_setting = 1'b0;
    tx_ready = 1'b0;
    tx_status_valid = 1'b0;
    tx_status_in = 16'h0000;
    stall_cnt = 2'h0;
    fcs_seen = 1'b0;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      group_table <= {63'h0, ~i[0]} << hv[i];
      rx_frame(12'h100, 64 + i, da[i], 1'b0, 2'b00, hv[i], 16'hFFFF, ~i[0]);
    end
    group_table <= '0;
    rx_frame(12'h500, 64, 8'hFF, 1'b1, 2'b11, 6'h00, 16'hFF81, 1'b0);
    rx_frame(12'h600, 63, 8'h02, 1'b0, 2'b10, 6'h00, 16'hFF81, 1'b0);
    rx_frame(12'h800, 1518, 8'h02, 1'b0, 2'b01, 6'h00, 16'hFF81, 1'b0);
    rx_frame(12'h800, 1519, 8'h02, 1'b0, 2'b00, 6'h00, 16'hFF81, 1'b0);
    rx_frame(12'h800, 1600, 8'h02, 1'b0, 2'b00, 6'h00, 16'hFF81, 1'b0);
    tx_frame(12'h100, 21, 1'b1, 1'b1, 1'b1);
    tx_frame(12'h200, 20, 1'b1, 1'b0, 1'b0);
    tx_frame(12'h300, 14, 1'b0, 1'b0, 1'b1);
    tx_frame(12'h300, 15, 1'b0, 1'b1, 1'b1);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
